/* File: rtl/smc_pkg.sv */
// Package for the per-socket mode and command register front end.
// Assumes a 32-bit AXI4-Lite register bus and one register word per printed index.
package smc_pkg;

    // Printed register positions are indices; the byte address is four times the index
    localparam logic [29:0] MODE_INDEX_BASE = 30'h00fe4000;
    localparam logic [29:0] CMD_INDEX_BASE = 30'h00fe4001;
    localparam logic [29:0] SOCKET_INDEX_STRIDE = 30'h00000100;
    localparam int SOCKET_FIELD_LSB = 8;

    // Reset values
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CMD_RESET = 8'h00;

    // Socket mode field positions
    localparam int MODE_MULTICAST_BIT = 7;
    localparam int MODE_MAC_FILTER_BIT = 6;
    localparam int MODE_NO_DELAY_ACK_OR_IGMP_VER_BIT = 5;
    localparam int MODE_PROTO_LSB = 0;
    localparam int MODE_PROTO_WIDTH = 4;
    // Bit 4 is reserved: dropped on write, zero on read
    localparam logic [7:0] MODE_WRITE_MASK = 8'hef;

    // Protocol selections
    localparam logic [3:0] PROTO_CLOSED = 4'h0;
    localparam logic [3:0] PROTO_TCP = 4'h1;
    localparam logic [3:0] PROTO_UDP = 4'h2;
    localparam logic [3:0] PROTO_RAW_IP = 4'h3;
    localparam logic [3:0] PROTO_RAW_MAC = 4'h4;
    localparam logic [3:0] PROTO_PPP_OVER_ETHERNET = 4'h5;

    // Command codes; all but CMD_NONE have a defined legality check
    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_OPEN = 8'h01;
    localparam logic [7:0] CMD_LISTEN = 8'h02;
    localparam logic [7:0] CMD_CONNECT = 8'h04;
    localparam logic [7:0] CMD_DISCONNECT = 8'h08;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : smc_pkg

/* File: rtl/smc_mode_decode.sv */
// Per-socket decode of the mode byte into option strobes, and legality of a pending command.
// Assumes mode and command bytes come straight from registers on the same clock.
`timescale 1ns/1ps
module smc_mode_decode #(
    parameter int SOCKET_INDEX = 0
) (
    input wire logic [7:0] socket_mode_reg,
    input wire logic [7:0] socket_command_reg,
    output logic [3:0] protocol_sel,
    output logic multicast_enable,
    output logic mac_filter_enable,
    output logic no_delay_ack,
    output logic delayed_ack,
    output logic igmp_ver1,
    output logic cmd_legal
);
    logic [3:0] proto_raw;
    logic is_tcp;
    logic is_udp;

    always_comb begin
        proto_raw = socket_mode_reg[smc_pkg::MODE_PROTO_LSB +: smc_pkg::MODE_PROTO_WIDTH];
        protocol_sel = proto_raw;
        // Raw MAC and PPPoE fall back to closed away from socket 0
        if ((SOCKET_INDEX != 0) && ((proto_raw == smc_pkg::PROTO_RAW_MAC) ||
                (proto_raw == smc_pkg::PROTO_PPP_OVER_ETHERNET))) begin
            protocol_sel = smc_pkg::PROTO_CLOSED;
        end
        // Codes above PPPoE select no protocol
        if (proto_raw > smc_pkg::PROTO_PPP_OVER_ETHERNET) begin
            protocol_sel = smc_pkg::PROTO_CLOSED;
        end
        is_tcp = (protocol_sel == smc_pkg::PROTO_TCP);
        is_udp = (protocol_sel == smc_pkg::PROTO_UDP);
        multicast_enable = socket_mode_reg[smc_pkg::MODE_MULTICAST_BIT] & is_udp;
        mac_filter_enable = socket_mode_reg[smc_pkg::MODE_MAC_FILTER_BIT];
        no_delay_ack = socket_mode_reg[smc_pkg::MODE_NO_DELAY_ACK_OR_IGMP_VER_BIT] & is_tcp;
        delayed_ack = ~socket_mode_reg[smc_pkg::MODE_NO_DELAY_ACK_OR_IGMP_VER_BIT] & is_tcp;
        igmp_ver1 = socket_mode_reg[smc_pkg::MODE_NO_DELAY_ACK_OR_IGMP_VER_BIT] & multicast_enable;
        unique case (socket_command_reg)
            smc_pkg::CMD_OPEN: cmd_legal = (protocol_sel != smc_pkg::PROTO_CLOSED);
            smc_pkg::CMD_LISTEN: cmd_legal = is_tcp;
            smc_pkg::CMD_CONNECT: cmd_legal = is_tcp;
            smc_pkg::CMD_DISCONNECT: cmd_legal = is_tcp;
            default: cmd_legal = 1'b1;
        endcase
    end
endmodule : smc_mode_decode

/* File: rtl/smc_socket_regs.sv */
// Socket mode and command registers behind an AXI4-Lite slave, one pair per socket.
// Assumes the socket protocol logic runs on aclk and pulses cmd_accept while cmd_valid is high.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module smc_socket_regs #(
    parameter int NUM_SOCKETS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic [NUM_SOCKETS-1:0] cmd_valid,
    output logic [NUM_SOCKETS-1:0][7:0] cmd_code,
    input wire logic [NUM_SOCKETS-1:0] cmd_accept,
    output logic [NUM_SOCKETS-1:0][3:0] protocol_sel,
    output logic [NUM_SOCKETS-1:0] multicast_enable,
    output logic [NUM_SOCKETS-1:0] mac_filter_enable,
    output logic [NUM_SOCKETS-1:0] no_delay_ack,
    output logic [NUM_SOCKETS-1:0] delayed_ack,
    output logic [NUM_SOCKETS-1:0] igmp_ver1
);

    typedef struct packed {
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane0;
        logic b_valid;
        logic [1:0] b_resp;
        logic r_valid;
        logic [7:0] r_byte;
        logic [1:0] r_resp;
        logic [NUM_SOCKETS-1:0][7:0] mode;
        logic [NUM_SOCKETS-1:0][7:0] cmd;
    } smc_state_type;

    typedef struct packed {
        logic hit;
        logic is_cmd;
        logic [7:0] socket;
    } smc_decode_type;

    smc_state_type state_q;
    smc_state_type state_d;
    logic [NUM_SOCKETS-1:0] legal;

    // Byte address to socket and register; misaligned or out-of-range addresses miss
    function automatic smc_decode_type decode_addr(input logic [31:0] addr);
        smc_decode_type res;
        logic [29:0] offs;
        offs = addr[31:2] - smc_pkg::MODE_INDEX_BASE;
        res.is_cmd = (offs[0] == smc_pkg::CMD_INDEX_BASE[0]);
        res.socket = offs[smc_pkg::SOCKET_FIELD_LSB +: 8];
        res.hit = (addr[1:0] == 2'h0) && (offs[7:1] == 7'h00) &&
            (offs < 30'(NUM_SOCKETS) * smc_pkg::SOCKET_INDEX_STRIDE);
        return res;
    endfunction : decode_addr

    generate
        for (genvar g = 0; g < NUM_SOCKETS; g++) begin : g_sock
            smc_mode_decode #(
                .SOCKET_INDEX(g)
            ) i_smc_mode_decode (
                .socket_mode_reg(state_q.mode[g]),
                .socket_command_reg(state_q.cmd[g]),
                .protocol_sel(protocol_sel[g]),
                .multicast_enable(multicast_enable[g]),
                .mac_filter_enable(mac_filter_enable[g]),
                .no_delay_ack(no_delay_ack[g]),
                .delayed_ack(delayed_ack[g]),
                .igmp_ver1(igmp_ver1[g]),
                .cmd_legal(legal[g])
            );
        end
    endgenerate

    // Readies drop while ce is low so no handshake is lost
    assign s_axi_awready = ce & ~state_q.aw_held;
    assign s_axi_wready = ce & ~state_q.w_held;
    assign s_axi_arready = ce & ~state_q.r_valid;
    assign s_axi_bvalid = state_q.b_valid;
    assign s_axi_bresp = state_q.b_resp;
    assign s_axi_rvalid = state_q.r_valid;
    assign s_axi_rdata = {24'h000000, state_q.r_byte};
    assign s_axi_rresp = state_q.r_resp;

    always_comb begin
        for (int n = 0; n < NUM_SOCKETS; n++) begin
            cmd_valid[n] = ce && (state_q.cmd[n] != smc_pkg::CMD_NONE) && legal[n];
            cmd_code[n] = state_q.cmd[n];
        end
    end

    always_comb begin
        smc_decode_type wdec;
        smc_decode_type rdec;
        state_d = state_q;
        wdec = decode_addr(state_q.aw_addr);
        rdec = decode_addr(s_axi_araddr);

        if (s_axi_awvalid && s_axi_awready) begin
            state_d.aw_held = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_d.w_held = 1'b1;
            state_d.w_byte = s_axi_wdata[7:0];
            state_d.w_lane0 = s_axi_wstrb[0];
        end

        // Accepted commands clear, the engine keeps running them afterwards; illegal ones clear at once
        for (int n = 0; n < NUM_SOCKETS; n++) begin
            if (state_q.cmd[n] != smc_pkg::CMD_NONE) begin
                if ((cmd_valid[n] && cmd_accept[n]) || !legal[n]) begin
                    state_d.cmd[n] = smc_pkg::CMD_NONE;
                end
            end
        end

        if (state_q.b_valid && s_axi_bready) begin
            state_d.b_valid = 1'b0;
        end
        // Write once address and data are both held; a new command beats a same-cycle clear
        if (state_q.aw_held && state_q.w_held && !state_q.b_valid) begin
            state_d.aw_held = 1'b0;
            state_d.w_held = 1'b0;
            state_d.b_valid = 1'b1;
            state_d.b_resp = wdec.hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
            if (wdec.hit && state_q.w_lane0) begin
                if (wdec.is_cmd) begin
                    state_d.cmd[wdec.socket] = state_q.w_byte;
                end else begin
                    state_d.mode[wdec.socket] = state_q.w_byte & smc_pkg::MODE_WRITE_MASK;
                end
            end
        end

        if (state_q.r_valid && s_axi_rready) begin
            state_d.r_valid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            state_d.r_valid = 1'b1;
            state_d.r_resp = rdec.hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
            state_d.r_byte = 8'h00;
            if (rdec.hit) begin
                state_d.r_byte = rdec.is_cmd ? state_q.cmd[rdec.socket]
                    : (state_q.mode[rdec.socket] & smc_pkg::MODE_WRITE_MASK);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= '0;
            for (int n = 0; n < NUM_SOCKETS; n++) begin
                state_q.mode[n] <= smc_pkg::MODE_RESET;
                state_q.cmd[n] <= smc_pkg::CMD_RESET;
            end
        end else if (ce) begin
            state_q <= state_d;
        end
    end

endmodule : smc_socket_regs

/* File: tb/smc_socket_regs_checker.sv */
// Assertions on the socket mode and command register front end.
// Bound to smc_socket_regs; sees its ports only.
`timescale 1ns/1ps
module smc_socket_regs_checker #(
    parameter int NUM_SOCKETS = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic s_axi_bvalid,
    input wire logic [NUM_SOCKETS-1:0] cmd_valid,
    input wire logic [NUM_SOCKETS-1:0][7:0] cmd_code,
    input wire logic [NUM_SOCKETS-1:0] cmd_accept,
    input wire logic [NUM_SOCKETS-1:0][3:0] protocol_sel,
    input wire logic [NUM_SOCKETS-1:0] multicast_enable,
    input wire logic [NUM_SOCKETS-1:0] no_delay_ack,
    input wire logic [NUM_SOCKETS-1:0] delayed_ack,
    input wire logic [NUM_SOCKETS-1:0] igmp_ver1
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_MC: assert property (multicast_enable[0] |-> protocol_sel[0] == smc_pkg::PROTO_UDP)
        else $error("multicast outside UDP");
    AST_ND: assert property (no_delay_ack[0] |-> protocol_sel[0] == smc_pkg::PROTO_TCP)
        else $error("immediate ack outside TCP");
    AST_DLY: assert property (protocol_sel[0] == smc_pkg::PROTO_TCP |-> delayed_ack[0] != no_delay_ack[0])
        else $error("ack mode not exclusive");
    AST_IGMP: assert property (igmp_ver1[0] |-> multicast_enable[0] && !no_delay_ack[0])
        else $error("igmp version without multicast");
    AST_RAW: assert property (!(protocol_sel[1] inside {4'h4, 4'h5}))
        else $error("raw protocol on socket 1");
    AST_RANGE: assert property (protocol_sel[0] <= smc_pkg::PROTO_PPP_OVER_ETHERNET)
        else $error("protocol out of range");
    AST_CLR: assert property (cmd_valid[0] && cmd_accept[0] |=> !cmd_valid[0] || $rose(s_axi_bvalid))
        else $error("command not cleared");
    AST_STAND: assert property (cmd_valid[0] && !cmd_accept[0] |=>
        !ce || (cmd_valid[0] && $stable(cmd_code[0])) || $rose(s_axi_bvalid)) else $error("command dropped");
    cover property (cmd_valid[0] && cmd_accept[0]);
    cover property (igmp_ver1[0]);
    cover property (no_delay_ack[0]);
endmodule : smc_socket_regs_checker
bind smc_socket_regs smc_socket_regs_checker #(.NUM_SOCKETS(NUM_SOCKETS)) i_smc_socket_regs_checker (.*);

/* File: tb/tb_smc_socket_regs.sv */
// Self-checking bench for smc_socket_regs with two sockets.
// Acts as AXI4-Lite master and as the engine pulsing cmd_accept.
`timescale 1ns/1ps
module tb_smc_socket_regs;
    localparam int NS = 2;
    typedef struct {logic [31:0] a; logic [7:0] m; logic [8:0] e;} smc_row_type;
    // Expected: multicast, mac filter, no delay, delayed, igmp v1, protocol
    smc_row_type rows [11] = '{'{32'h03f90000, 8'h21, 9'h041}, '{32'h03f90000, 8'h01, 9'h021},
        '{32'h03f90000, 8'ha2, 9'h112}, '{32'h03f90000, 8'h82, 9'h102}, '{32'h03f90000, 8'h81, 9'h021},
        '{32'h03f90000, 8'h53, 9'h083}, '{32'h03f90000, 8'h04, 9'h004}, '{32'h03f90000, 8'h05, 9'h005},
        '{32'h03f90400, 8'h04, 9'h000}, '{32'h03f90400, 8'h25, 9'h000}, '{32'h03f90000, 8'h00, 9'h000}};
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [NS-1:0] cmd_accept = 2'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd;
    logic [NS-1:0] cmd_valid, multicast_enable, mac_filter_enable, no_delay_ack, delayed_ack, igmp_ver1;
    logic [NS-1:0][7:0] cmd_code;
    logic [NS-1:0][3:0] protocol_sel;
    int err_total = 0, tests_run = 0, cyc = 0, s;
    smc_socket_regs #(.NUM_SOCKETS(NS)) i_smc_socket_regs (.*);
    always #5 aclk = ~aclk;
    task automatic summarize();
        $display("tests_run=%0d err_total=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awvalid & s_axi_awready;
            w_t = s_axi_wvalid & s_axi_wready;
            b_t = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'h0;
            if (w_t) s_axi_wvalid <= 1'h0;
        end while (!b_t);
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rdr(input logic [31:0] a);
        logic ar_t, r_t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arvalid & s_axi_arready;
            r_t = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'h0;
        end while (!r_t);
        s_axi_rready <= 1'h0;
    endtask : rdr
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rdr(32'h03f90000);
        chk(rd, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].m);
            s = rows[i].a[10];
            chk({multicast_enable[s], mac_filter_enable[s], no_delay_ack[s], delayed_ack[s], igmp_ver1[s],
                protocol_sel[s]}, rows[i].e);
            rdr(rows[i].a);
            chk(rd, {24'h0, rows[i].m & 8'hef});
        end
        wr(32'h03f90000, 8'h01);
        wr(32'h03f90400, 8'h01);
        wr(32'h03f90004, 8'h01);
        wr(32'h03f90404, 8'h04);
        chk({cmd_valid, cmd_code[1], cmd_code[0]}, 32'h30401);
        rdr(32'h03f90004);
        chk(rd, 32'h1);
        cmd_accept <= 2'h3;
        @(posedge aclk);
        cmd_accept <= 2'h0;
        rdr(32'h03f90404);
        chk(rd, 32'h0);
        chk(32'(cmd_valid), 32'h0);
        wr(32'h03f90000, 8'h02);
        wr(32'h03f90004, 8'h02);
        chk(cmd_valid, 32'h0);
        rdr(32'h03f90004);
        chk(rd, 32'h0);
        wr(32'h03f90000, 8'h00);
        wr(32'h03f90004, 8'h01);
        chk(cmd_valid, 32'h0);
        rdr(32'h03f90008);
        chk(resp, smc_pkg::RESP_SLVERR);
        wr(32'h03f90000, 8'h01);
        wr(32'h03f90004, 8'h01);
        ce <= 1'h0;
        @(negedge aclk);
        chk({s_axi_awready, s_axi_wready, s_axi_arready, cmd_valid}, 32'h0);
        @(posedge aclk);
        ce <= 1'h1;
        @(negedge aclk);
        chk(32'(cmd_valid), 32'h1);
        summarize();
    end
endmodule : tb_smc_socket_regs
